// *** rtl/pxo_pkg.sv ***
// Purpose: shared constants and types of the pixel output port
// Assumes: a 10-bit monochrome stream, one word per master clock period
// Notes:   frame geometry defaults give 1280 x 1024 active pixels
package pxo_pkg;

   // pixel word
   localparam int PIX_W = 10;
   localparam int CNT_W = 11;

   // default geometry, in pixel clocks and rows
   localparam int H_ACTIVE_DEF   = 1280;
   localparam int H_BLANK_DEF    = 244;
   localparam int V_ACTIVE_DEF   = 1024;
   localparam int V_BLANK_DEF    = 26;
   localparam int RESET_ROWS_DEF = 2;

   // line-valid qualifier modes
   typedef enum logic [1:0] {
      LV_NORMAL     = 2'b00,
      LV_CONTINUOUS = 2'b01,
      LV_XOR        = 2'b10
   } pxo_lv_mode_t;

   // configuration register image
   typedef struct packed {
      pxo_lv_mode_t lvMode;
      logic         snapshot;
   } pxo_cfg_t;

   localparam pxo_cfg_t CFG_DEFAULT = '{lvMode: LV_NORMAL, snapshot: 1'b0};

   // one pixel clock worth of link output
   typedef struct packed {
      logic             frameValid;
      logic             lineValid;
      logic             strobe;
      logic [PIX_W-1:0] data;
   } pxo_word_t;

   localparam int WORD_W = $bits(pxo_word_t);
   localparam pxo_word_t WORD_IDLE = '{frameValid: 1'b0, lineValid: 1'b0, strobe: 1'b0, data: 10'h000};

   // readout sequencer
   typedef enum logic [1:0] {
      ST_IDLE        = 2'b00,
      ST_ARRAY_RESET = 2'b01,
      ST_FRAME       = 2'b10
   } pxo_state_t;

endpackage

// *** rtl/pxo_cdc_fifo.sv ***
// Purpose: small dual-clock buffer carrying pixel words to the link domain
// Assumes: depth is a power of two, resets are released synchronously per side
// Notes:   gray pointers cross through two flip-flops each way
`timescale 1ns/100ps
module pxo_cdc_fifo #(
   parameter int WIDTH = 13,
   parameter int AW    = 1
) (
   // write side
   input  wire logic             wrClk,
   input  wire logic             wrRst_b,
   input  wire logic             wrValid,
   output logic                  wrReady,
   input  wire logic [WIDTH-1:0] wrData,
   // read side
   input  wire logic             rdClk,
   input  wire logic             rdRst_b,
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic [WIDTH-1:0]      rdData
);

   localparam int DEPTH = 1 << AW;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wrBin_q;
   logic [AW:0]      rdBin_q;
   logic [AW:0]      wrGray_q;
   logic [AW:0]      rdGray_q;
   logic [AW:0]      rdGrayS1_q;
   logic [AW:0]      rdGrayS2_q;
   logic [AW:0]      wrGrayS1_q;
   logic [AW:0]      wrGrayS2_q;
   logic [AW:0]      rdBinAtWr;
   logic [AW:0]      wrBinNext;
   logic [AW:0]      rdBinNext;
   wire              doWrite;
   wire              doRead;

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   assign rdBinAtWr = gray2bin(rdGrayS2_q);
   assign wrReady   = !((wrBin_q[AW-1:0] == rdBinAtWr[AW-1:0]) && (wrBin_q[AW] != rdBinAtWr[AW]));
   assign rdValid   = (rdGray_q != wrGrayS2_q);
   assign doWrite   = wrValid && wrReady;
   assign doRead    = rdValid && rdReady;
   assign wrBinNext = wrBin_q + (AW+1)'(1);
   assign rdBinNext = rdBin_q + (AW+1)'(1);
   assign rdData    = mem_q[rdBin_q[AW-1:0]];

   always_ff @(posedge wrClk) begin
      if (doWrite) begin
         mem_q[wrBin_q[AW-1:0]] <= wrData;
      end
   end

   always_ff @(posedge wrClk or negedge wrRst_b) begin
      if (!wrRst_b) begin
         wrBin_q    <= '0;
         wrGray_q   <= '0;
         rdGrayS1_q <= '0;
         rdGrayS2_q <= '0;
      end else begin
         rdGrayS1_q <= rdGray_q;
         rdGrayS2_q <= rdGrayS1_q;
         if (doWrite) begin
            wrBin_q  <= wrBinNext;
            wrGray_q <= wrBinNext ^ (wrBinNext >> 1);
         end
      end
   end

   always_ff @(posedge rdClk or negedge rdRst_b) begin
      if (!rdRst_b) begin
         rdBin_q    <= '0;
         rdGray_q   <= '0;
         wrGrayS1_q <= '0;
         wrGrayS2_q <= '0;
      end else begin
         wrGrayS1_q <= wrGray_q;
         wrGrayS2_q <= wrGrayS1_q;
         if (doRead) begin
            rdBin_q  <= rdBinNext;
            rdGray_q <= rdBinNext ^ (rdBinNext >> 1);
         end
      end
   end

endmodule

// *** rtl/pxo_pixel_port.sv ***
// Purpose: pixel output port with frame/line qualifiers, pixel clock and strobe
// Assumes: ref_clk clocks the readout sequencer, masterClockIn clocks the pins
// Notes:   pixel words cross to the pin domain through a two-entry buffer
`timescale 1ns/100ps

// Notes on behaviour
// - While the output-disable pin is high, every pixel-side output is released to high impedance.
// - A low reset pin resets the block at once, without waiting for a clock edge.
// - Reset returns every configuration register to its default value.
// - A high standby pin switches the analog bias off and stops readout.
// - A high trigger pin starts a snapshot capture sequence.
// - Each pixel is one 10-bit word with bit 9 most significant and bit 0 least.
// - Frame-valid is high through the whole frame of valid pixel data and low otherwise.
// - Line-valid is high during each line of valid data, qualified in a configurable way.
// - Pixel data stays stable around the falling pixel clock edge, where the capture side samples it.
// - The pixel clock runs at the master clock frequency, in step with the qualifiers and data.
// - A strobe pulse marks the end of the pixel array reset.
// - Without reprogramming the block delivers 1280 by 1024 images of 10-bit pixels.
// - While line-valid is high exactly one pixel word is output per pixel clock period.
// - The pixel clock keeps toggling through horizontal and vertical blanking.
module pxo_pixel_port #(
   parameter int H_ACTIVE   = pxo_pkg::H_ACTIVE_DEF,
   parameter int H_BLANK    = pxo_pkg::H_BLANK_DEF,
   parameter int V_ACTIVE   = pxo_pkg::V_ACTIVE_DEF,
   parameter int V_BLANK    = pxo_pkg::V_BLANK_DEF,
   parameter int RESET_ROWS = pxo_pkg::RESET_ROWS_DEF,
   parameter int BUF_AW     = 1
) (
   // core clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst_b,
   // link clock
   input  wire logic                       masterClockIn,
   // control pins
   input  wire logic                       standby,
   input  wire logic                       trigger,
   input  wire logic                       outDisable,
   // configuration load, ref_clk domain
   input  wire logic                       cfgLoad,
   input  wire pxo_pkg::pxo_lv_mode_t      cfgLvMode,
   input  wire logic                       cfgSnapshot,
   // pixel pins, each with its output enable
   output logic [pxo_pkg::PIX_W-1:0]       pixData,
   output logic                            pixDataOe,
   output logic                            frameValid,
   output logic                            frameValidOe,
   output logic                            lineValid,
   output logic                            lineValidOe,
   output logic                            pixelSampleClock,
   output logic                            pixelSampleClockOe,
   output logic                            strobe,
   output logic                            strobeOe,
   // analog control and status
   output logic                            biasEnable,
   output pxo_pkg::pxo_state_t             seqState
);

   localparam int                  CW        = pxo_pkg::CNT_W;
   localparam logic [CW-1:0]       ROW_LAST  = CW'(H_ACTIVE + H_BLANK - 1);
   localparam logic [CW-1:0]       ROWS_LAST = CW'(V_ACTIVE + V_BLANK - 1);
   localparam logic [CW-1:0]       COL_ACT   = CW'(H_ACTIVE);
   localparam logic [CW-1:0]       ROW_ACT   = CW'(V_ACTIVE);
   localparam logic [CW-1:0]       RST_LAST  = CW'(RESET_ROWS - 1);

   // ---------------------------------------------------------------
   // reset release per domain: assert at once, release on a clock
   // ---------------------------------------------------------------
   logic       coreRstS1_q;
   logic       coreRst_b_q;
   logic       linkRstS1_q;
   logic       linkRst_b_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         coreRstS1_q <= 1'b0;
         coreRst_b_q <= 1'b0;
      end else begin
         coreRstS1_q <= 1'b1;
         coreRst_b_q <= coreRstS1_q;
      end
   end

   always_ff @(posedge masterClockIn or negedge rst_b) begin
      if (!rst_b) begin
         linkRstS1_q <= 1'b0;
         linkRst_b_q <= 1'b0;
      end else begin
         linkRstS1_q <= 1'b1;
         linkRst_b_q <= linkRstS1_q;
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers into the core domain
   // ---------------------------------------------------------------
   logic       standbyS1_q;
   logic       standbyS2_q;
   logic       triggerS1_q;
   logic       triggerS2_q;
   logic       triggerPrev_q;
   logic       trigPend_q;
   logic       trigPend_d;
   wire        trigRise;
   wire        trigTaken;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         standbyS1_q   <= 1'b0;
         standbyS2_q   <= 1'b0;
         triggerS1_q   <= 1'b0;
         triggerS2_q   <= 1'b0;
         triggerPrev_q <= 1'b0;
      end else begin
         standbyS1_q   <= standby;
         standbyS2_q   <= standbyS1_q;
         triggerS1_q   <= trigger;
         triggerS2_q   <= triggerS1_q;
         triggerPrev_q <= triggerS2_q;
      end
   end

   assign trigRise = triggerS2_q && !triggerPrev_q;

   // ---------------------------------------------------------------
   // configuration register
   // ---------------------------------------------------------------
   pxo_pkg::pxo_cfg_t cfg_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= pxo_pkg::CFG_DEFAULT;
      end else if (cfgLoad) begin
         cfg_q <= '{lvMode: cfgLvMode, snapshot: cfgSnapshot};
      end
   end

   // ---------------------------------------------------------------
   // readout sequencer
   // ---------------------------------------------------------------
   pxo_pkg::pxo_state_t state_q;
   pxo_pkg::pxo_state_t state_d;
   logic [CW-1:0]       col_q;
   logic [CW-1:0]       col_d;
   logic [CW-1:0]       row_q;
   logic [CW-1:0]       row_d;
   logic                bias_q;
   wire                 wrReady;
   wire                 rowEnd;
   wire                 frameEnd;
   wire                 resetDone;
   wire                 inFrame;
   wire                 actCol;
   wire                 actRow;
   wire                 fvRaw;
   wire                 lvRaw;
   logic                lvSel;
   wire [pxo_pkg::PIX_W-1:0] ramp;
   pxo_pkg::pxo_word_t  word;

   assign rowEnd    = (col_q == ROW_LAST);
   assign frameEnd  = rowEnd && (row_q == ROWS_LAST);
   assign resetDone = (state_q == pxo_pkg::ST_ARRAY_RESET) && rowEnd && (row_q == RST_LAST);
   assign trigTaken = (state_q == pxo_pkg::ST_IDLE) && !standbyS2_q && cfg_q.snapshot && trigPend_q;
   // set wins over the clear so a trigger in the taking cycle is kept
   assign trigPend_d = trigRise || (trigPend_q && !trigTaken);

   always_comb begin
      state_d = state_q;
      col_d   = col_q;
      row_d   = row_q;
      case (state_q)
         pxo_pkg::ST_IDLE: begin
            col_d = '0;
            row_d = '0;
            if (standbyS2_q) begin
               state_d = pxo_pkg::ST_IDLE;
            end else if (!cfg_q.snapshot) begin
               state_d = pxo_pkg::ST_FRAME;
            end else if (trigPend_q) begin
               state_d = pxo_pkg::ST_ARRAY_RESET;
            end
         end
         pxo_pkg::ST_ARRAY_RESET: begin
            if (wrReady) begin
               col_d = rowEnd ? '0 : col_q + CW'(1);
               row_d = rowEnd ? row_q + CW'(1) : row_q;
               if (resetDone) begin
                  state_d = pxo_pkg::ST_FRAME;
                  row_d   = '0;
               end
            end
         end
         pxo_pkg::ST_FRAME: begin
            if (wrReady) begin
               col_d = rowEnd ? '0 : col_q + CW'(1);
               row_d = rowEnd ? row_q + CW'(1) : row_q;
               if (frameEnd) begin
                  row_d = '0;
                  // standby or snapshot only take effect between frames
                  if (standbyS2_q || cfg_q.snapshot) begin
                     state_d = pxo_pkg::ST_IDLE;
                  end
               end
            end
         end
         default: begin
            state_d = pxo_pkg::ST_IDLE;
            col_d   = '0;
            row_d   = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge coreRst_b_q) begin
      if (!coreRst_b_q) begin
         state_q    <= pxo_pkg::ST_IDLE;
         col_q      <= '0;
         row_q      <= '0;
         trigPend_q <= 1'b0;
         bias_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         col_q      <= col_d;
         row_q      <= row_d;
         trigPend_q <= trigPend_d;
         bias_q     <= !standbyS2_q;
      end
   end

   assign biasEnable = bias_q;
   assign seqState   = state_q;

   // ---------------------------------------------------------------
   // word assembly
   // ---------------------------------------------------------------
   assign inFrame = (state_q == pxo_pkg::ST_FRAME);
   assign actCol  = (col_q < COL_ACT);
   assign actRow  = (row_q < ROW_ACT);
   assign fvRaw   = inFrame && actRow;
   assign lvRaw   = fvRaw && actCol;
   // synthetic ramp stands in for the column converters
   assign ramp    = col_q[pxo_pkg::PIX_W-1:0] + row_q[pxo_pkg::PIX_W-1:0];

   always_comb begin
      case (cfg_q.lvMode)
         pxo_pkg::LV_NORMAL:     lvSel = lvRaw;
         pxo_pkg::LV_CONTINUOUS: lvSel = inFrame && actCol;
         pxo_pkg::LV_XOR:        lvSel = fvRaw ^ lvRaw;
         default:                lvSel = lvRaw;
      endcase
   end

   assign word.frameValid = fvRaw;
   assign word.lineValid  = lvSel;
   assign word.strobe     = resetDone;
   assign word.data       = lvRaw ? ramp : '0;

   // ---------------------------------------------------------------
   // crossing buffer; a full buffer stalls the sequencer
   // ---------------------------------------------------------------
   wire [pxo_pkg::WORD_W-1:0] rdWord;
   wire                       rdValid;
   logic                      oeS1_q;
   logic                      oeS2_q;

   pxo_cdc_fifo #(
      .WIDTH (pxo_pkg::WORD_W),
      .AW    (BUF_AW)
   ) u_buf (
      .wrClk   (ref_clk),
      .wrRst_b (coreRst_b_q),
      .wrValid (1'b1),
      .wrReady (wrReady),
      .wrData  (word),
      .rdClk   (masterClockIn),
      .rdRst_b (linkRst_b_q),
      .rdValid (rdValid),
      .rdReady (oeS2_q),
      .rdData  (rdWord)
   );

   // ---------------------------------------------------------------
   // pin domain
   // ---------------------------------------------------------------
   pxo_pkg::pxo_word_t out_q;
   pxo_pkg::pxo_word_t out_d;
   pxo_pkg::pxo_word_t popWord;

   assign popWord = pxo_pkg::pxo_word_t'(rdWord);

   // an empty buffer is shown as blanking, frame-valid held
   always_comb begin
      out_d = out_q;
      if (oeS2_q) begin
         if (rdValid) begin
            out_d = popWord;
         end else begin
            out_d.lineValid = 1'b0;
            out_d.strobe    = 1'b0;
            out_d.data      = '0;
         end
      end
   end

   always_ff @(posedge masterClockIn or negedge linkRst_b_q) begin
      if (!linkRst_b_q) begin
         oeS1_q <= 1'b0;
         oeS2_q <= 1'b0;
         out_q  <= pxo_pkg::WORD_IDLE;
      end else begin
         oeS1_q <= !outDisable;
         oeS2_q <= oeS1_q;
         // launched on the rising edge, settled by the falling edge
         out_q  <= out_d;
      end
   end

   assign pixData    = out_q.data;
   assign frameValid = out_q.frameValid;
   assign lineValid  = out_q.lineValid;
   assign strobe     = out_q.strobe;
   // free running copy of the master clock, blanking included
   assign pixelSampleClock = masterClockIn;

   assign pixDataOe          = oeS2_q;
   assign frameValidOe       = oeS2_q;
   assign lineValidOe        = oeS2_q;
   assign pixelSampleClockOe = oeS2_q;
   assign strobeOe           = oeS2_q;

endmodule

// *** tb/pxo_pixel_port_checker.sv ***
// Purpose: pin-level assertions of the pixel output port
// Assumes: bench geometry passed on through bind
// Notes:   line-length and ramp checks are gated by the data output enable
`timescale 1ns/100ps
module pxo_pixel_port_checker #(
   parameter int H_ACTIVE = 8,
   parameter int H_BLANK  = 4,
   parameter int V_ACTIVE = 4
) (
   // clocks and reset
   input wire logic                       ref_clk,
   input wire logic                       rst_b,
   input wire logic                       masterClockIn,
   // control pins
   input wire logic                       standby,
   input wire logic                       outDisable,
   // pixel pins
   input wire logic [pxo_pkg::PIX_W-1:0]  pixData,
   input wire logic                       pixDataOe,
   input wire logic                       frameValid,
   input wire logic                       frameValidOe,
   input wire logic                       lineValid,
   input wire logic                       lineValidOe,
   input wire logic                       pixelSampleClock,
   input wire logic                       pixelSampleClockOe,
   input wire logic                       strobe,
   input wire logic                       strobeOe,
   // status
   input wire logic                       biasEnable,
   input wire pxo_pkg::pxo_state_t        seqState
);
   logic [7:0] lvRun_q;
   logic [7:0] lvRun_d;
   logic       anyOe;

   // line words of one frame: buffer gaps delay words, never drop them
   assign lvRun_d = frameValid ? lvRun_q + 8'(lineValid && pixDataOe) : 8'h00;
   assign anyOe   = pixDataOe | frameValidOe | lineValidOe | pixelSampleClockOe | strobeOe;

   always_ff @(posedge masterClockIn) begin
      lvRun_q <= lvRun_d;
   end

   // no disable: it checks the reset itself
   property p_rstQuiet;
      @(posedge ref_clk) !rst_b [*3] |-> !frameValid && !lineValid && !strobe && !anyOe && !biasEnable
         && seqState == pxo_pkg::ST_IDLE;
   endproperty
   a_rstQuiet: assert property (p_rstQuiet) else $error("outputs active in reset");

   property p_oeOff;
      @(posedge masterClockIn) disable iff (!rst_b) outDisable [*3] |-> !anyOe;
   endproperty
   a_oeOff: assert property (p_oeOff) else $error("pin still driven while disabled");

   property p_oeOn;
      @(posedge masterClockIn) disable iff (!rst_b) !outDisable [*8] |-> pixDataOe && frameValidOe && lineValidOe
         && pixelSampleClockOe && strobeOe;
   endproperty
   a_oeOn: assert property (p_oeOn) else $error("pin not driven while enabled");

   property p_pixel_sample_clock;
      @(posedge ref_clk) disable iff (!rst_b) pixelSampleClock == masterClockIn;
   endproperty
   a_pixel_sample_clock: assert property (p_pixel_sample_clock) else $error("pixel clock not following master clock");

   property p_dataZero;
      @(posedge masterClockIn) disable iff (!rst_b) !frameValid |-> pixData == 10'h000;
   endproperty
   a_dataZero: assert property (p_dataZero) else $error("data not blank outside frame");

   property p_lineLen;
      @(posedge masterClockIn) disable iff (!rst_b) $fell(frameValid) && pixDataOe |->
         int'(lvRun_q) == V_ACTIVE * H_ACTIVE || int'(lvRun_q) == V_ACTIVE * H_BLANK;
   endproperty
   a_lineLen: assert property (p_lineLen) else $error("line words wrong");

   property p_ramp;
      @(posedge masterClockIn) disable iff (!rst_b)
         pixData != 10'h000 && $past(pixData) != 10'h000 && pixDataOe && $past(pixDataOe)
         |-> pixData == $past(pixData) + 10'h001;
   endproperty
   a_ramp: assert property (p_ramp) else $error("pixel word out of order");

   property p_strobe;
      @(posedge masterClockIn) disable iff (!rst_b) strobe |=> !strobe ##[0:7] frameValid;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not one cycle before frame");

   property p_biasOff;
      @(posedge ref_clk) disable iff (!rst_b) standby [*4] |-> !biasEnable;
   endproperty
   a_biasOff: assert property (p_biasOff) else $error("bias on in standby");

   property p_biasOn;
      @(posedge ref_clk) disable iff (!rst_b) !standby [*8] |-> biasEnable;
   endproperty
   a_biasOn: assert property (p_biasOn) else $error("bias off out of standby");
endmodule

bind pxo_pixel_port pxo_pixel_port_checker #(.H_ACTIVE(H_ACTIVE), .H_BLANK(H_BLANK), .V_ACTIVE(V_ACTIVE))
   u_pxo_pixel_port_checker (
   .ref_clk, .rst_b, .masterClockIn, .standby, .outDisable, .pixData, .pixDataOe, .frameValid,
   .frameValidOe, .lineValid, .lineValidOe, .pixelSampleClock, .pixelSampleClockOe, .strobe,
   .strobeOe, .biasEnable, .seqState
);

// *** tb/pxo_capture_model.sv ***
// Purpose: capture logic on the far side of the pixel pins
// Assumes: pins already resolved from their output enables
// Notes:   one captured word per falling pixel clock edge
`timescale 1ns/100ps
module pxo_capture_model (
   // board pins
   input  wire logic       pixel_sample_clock,
   input  wire logic [9:0] pinData,
   input  wire logic       pinFv,
   input  wire logic       pinLv,
   input  wire logic       pinStrobe,
   // captured result
   output logic            capValid,
   output logic [9:0]      capData,
   output logic [31:0]     strobeCount
);
   initial strobeCount = 32'h0;

   always @(negedge pixel_sample_clock) begin
      capValid <= pinFv && pinLv;
      capData  <= pinData;
      if (pinStrobe) begin
         strobeCount <= strobeCount + 32'h1;
      end
   end
endmodule

// *** tb/pxo_pixel_port_bench.sv ***
// Purpose: self-checking bench of the pixel output port
// Assumes: shrunk frame geometry, snapshot frames for exact expectations
// Notes:   watcher compares captured words against a queue of notes
`timescale 1ns/100ps
module pxo_pixel_port_bench;
   localparam int H_A = 8;
   localparam int H_B = 4;
   localparam int V_A = 4;

   logic                  ref_clk, rst_b, masterClockIn, standby, trigger, outDisable, cfgLoad, cfgSnapshot;
   pxo_pkg::pxo_lv_mode_t cfgLvMode;
   logic [9:0]            pixData, pinData, capData;
   logic                  pixDataOe, frameValid, frameValidOe, lineValid, lineValidOe, strobe, strobeOe;
   logic                  pixelSampleClock, pixelSampleClockOe, biasEnable, capValid, watchOn;
   pxo_pkg::pxo_state_t   seqState;
   logic [31:0]           strobeCount;
   logic [9:0]            expQ[$];
   int                    miscompares, cmpCount, tick, strobeBase;
   integer                seed;
   pxo_pkg::pxo_lv_mode_t modes[3] = '{pxo_pkg::LV_NORMAL, pxo_pkg::LV_CONTINUOUS, pxo_pkg::LV_XOR};

   pxo_pixel_port #(.H_ACTIVE(H_A), .H_BLANK(H_B), .V_ACTIVE(V_A), .V_BLANK(2), .RESET_ROWS(1),
      .BUF_AW(1)) u_pxo_pixel_port (
      .ref_clk(ref_clk), .rst_b(rst_b), .masterClockIn(masterClockIn), .standby(standby),
      .trigger(trigger), .outDisable(outDisable), .cfgLoad(cfgLoad), .cfgLvMode(cfgLvMode),
      .cfgSnapshot(cfgSnapshot), .pixData(pixData), .pixDataOe(pixDataOe), .frameValid(frameValid),
      .frameValidOe(frameValidOe), .lineValid(lineValid), .lineValidOe(lineValidOe),
      .pixelSampleClock(pixelSampleClock), .pixelSampleClockOe(pixelSampleClockOe), .strobe(strobe),
      .strobeOe(strobeOe), .biasEnable(biasEnable), .seqState(seqState)
   );

   // released pins float: show the inverse so stale values never pass
   assign pinData = pixDataOe ? pixData : ~pixData;

   pxo_capture_model u_pxo_capture_model (
      .pixel_sample_clock(pixelSampleClockOe ? pixelSampleClock : ~pixelSampleClock), .pinData(pinData),
      .pinFv(frameValidOe ? frameValid : ~frameValid), .pinLv(lineValidOe ? lineValid : ~lineValid),
      .pinStrobe(strobeOe ? strobe : ~strobe), .capValid(capValid), .capData(capData),
      .strobeCount(strobeCount)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // 12.5 MHz, offset from the core clock edges
   initial begin
      masterClockIn = 1'b0;
      #13;
      forever #40 masterClockIn = ~masterClockIn;
   end

   task automatic wrapUp;
      $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cmpPix(input logic [9:0] exp, input logic [9:0] got);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: pixel %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmpState(input pxo_pkg::pxo_state_t got, input pxo_pkg::pxo_state_t exp);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: state %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %0d, expected %0d", $time, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic waitState(input pxo_pkg::pxo_state_t s);
      for (int n = 0; n < 2000 && seqState !== s; n++) @(posedge ref_clk);
   endtask

   // note every word captured in one frame
   task automatic pushFrame(input pxo_pkg::pxo_lv_mode_t m);
      for (int r = 0; r < V_A; r++)
         for (int c = 0; c < ((m == pxo_pkg::LV_XOR) ? H_B : H_A); c++)
            expQ.push_back((m == pxo_pkg::LV_XOR) ? 10'h000 : 10'(r + c));
   endtask

   task automatic loadCfg(input pxo_pkg::pxo_lv_mode_t m, input logic s);
      @(posedge ref_clk);
      cfgLoad     <= 1'b1;
      cfgLvMode   <= m;
      cfgSnapshot <= s;
      @(posedge ref_clk);
      cfgLoad     <= 1'b0;
   endtask

   task automatic snap;
      int hold;
      hold = 2 + ($random(seed) & 3);
      @(posedge ref_clk);
      trigger <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      trigger <= 1'b0;
   endtask

   always @(posedge masterClockIn) begin
      if (watchOn && capValid) begin
         if (expQ.size() == 0) begin
            miscompares++;
            $display("wrong value at %0t: unexpected pixel %h", $time, capData);
         end else
            cmpPix(expQ.pop_front(), capData);
      end
   end

   always @(posedge ref_clk) begin
      tick++;
      if (tick == 30000) begin
         miscompares++;
         wrapUp();
      end
   end

   initial begin
      seed = 32'h0ac9;
      rst_b = 1'b0;
      standby = 1'b0;
      trigger = 1'b0;
      outDisable = 1'b0;
      cfgLoad = 1'b0;
      cfgSnapshot = 1'b0;
      cfgLvMode = pxo_pkg::LV_NORMAL;
      watchOn = 1'b0;
      cycles(5);
      rst_b <= 1'b1;
      cycles(4);
      loadCfg(pxo_pkg::LV_NORMAL, 1'b1);
      cycles(5);
      waitState(pxo_pkg::ST_IDLE);
      cycles(40);
      strobeBase = strobeCount;
      foreach (modes[i]) begin
         loadCfg(modes[i], 1'b1);
         cycles(10);
         cmpState(seqState, pxo_pkg::ST_IDLE);
         pushFrame(modes[i]);
         watchOn = 1'b1;
         snap();
         waitState(pxo_pkg::ST_ARRAY_RESET);
         cmpState(seqState, pxo_pkg::ST_ARRAY_RESET);
         waitState(pxo_pkg::ST_IDLE);
         cycles(40);
         cmpVal(expQ.size(), 0);
         cmpVal(strobeCount, strobeBase + i + 1);
      end
      standby <= 1'b1;
      cycles(6);
      cmpVal({31'h0, biasEnable}, 0);
      standby <= 1'b0;
      cycles(6);
      cmpVal({31'h0, biasEnable}, 1);
      watchOn = 1'b0;
      snap();
      cycles(100);
      outDisable <= 1'b1;
      cycles(10);
      cmpVal({27'h0, pixDataOe, frameValidOe, lineValidOe, pixelSampleClockOe, strobeOe}, 0);
      rst_b <= 1'b0;
      outDisable <= 1'b0;
      #1;
      cmpVal({28'h0, frameValid, lineValid, strobe, biasEnable}, 0);
      cmpPix(10'h000, pixData);
      cycles(5);
      cmpState(seqState, pxo_pkg::ST_IDLE);
      rst_b <= 1'b1;
      expQ.delete();
      // defaults run free: catch the second frame whole
      for (int n = 0; n < 2000 && frameValid !== 1'b1; n++) @(posedge ref_clk);
      for (int n = 0; n < 2000 && frameValid !== 1'b0; n++) @(posedge ref_clk);
      pushFrame(pxo_pkg::LV_NORMAL);
      watchOn = 1'b1;
      for (int n = 0; n < 2000 && expQ.size() != 0; n++) @(posedge ref_clk);
      watchOn = 1'b0;
      cmpVal(expQ.size(), 0);
      wrapUp();
   end
endmodule
